// ==== src/auto_xfer_pkg.sv ====
// constants for the automatic serial transfer control block
// assumes an 8-bit processor data bus with byte and bit writes
package auto_xfer_pkg;
  localparam logic [15:0] GAP_ADDR      = 16'hFF65;
  localparam logic [15:0] CTRL_ADDR     = 16'hFF64;
  localparam logic [15:0] MODE_ADDR     = 16'hFF63;
  localparam logic [15:0] SHIFT_ADDR    = 16'hFF1A;
  localparam logic [7:0]  GAP_RESET     = 8'h00;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam int          CTRL_RX_BIT   = 7;
  localparam int          CTRL_RPT_BIT  = 6;
  localparam int          CTRL_CHK_BIT  = 5;
  localparam int          CTRL_ERR_BIT  = 4;
  localparam int          CTRL_ACT_BIT  = 3;
  localparam int          CTRL_BEN_BIT  = 1;
  localparam int          CTRL_BPOL_BIT = 0;
  localparam int          MODE_EN_BIT   = 7;
  localparam int          GAP_SEL_BIT   = 7;
  localparam logic [7:0]  CTRL_WMASK    = 8'hE3;
  localparam logic [7:0]  GAP_WMASK     = 8'h9F;
  localparam logic [5:0]  GAP_DEFAULT   = 6'h02;
  localparam int          CLOCK_NS      = 40;
endpackage

// ==== src/gap_timer.sv ====
// inter-byte gap counter on the serial clock domain
// assumes load pulse and code come in already synchronised to link_clk
`timescale 1ns/1ps
module gap_timer #(
  parameter int CW = 6
) (
  input  wire logic          link_clk,
  input  wire logic          link_rst,
  input  wire logic          load,
  input  wire logic [CW-1:0] periods,
  output logic               gap_done
);
  logic [CW-1:0] count_reg;
  logic          run_reg;

  if (CW < 6) begin : g_cw_check
    $error("gap_timer needs at least 6 bits");
  end

  // reload from the code before each byte, count down serial periods
  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      count_reg <= '0;
      run_reg   <= 1'b0;
    end else if (load) begin
      count_reg <= periods;
      run_reg   <= 1'b1;
    end else if (run_reg && count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end else begin
      run_reg <= 1'b0;
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      gap_done <= 1'b0;
    end else begin
      gap_done <= run_reg && count_reg == CW'(1) && !load;
    end
  end
endmodule

// ==== src/auto_serial_transfer_control.sv ====
// control and status of the automatic multi-byte 3-wire serial transfer
// assumes a byte-wide processor bus, byte writes with a bit mask for bit ops,
// and a byte engine that reports byte ends and faults on sys_clk
// How it works
// - error flag reads 1 after a fault, clears when the shift register is written
// - faults are checked only with check enable and busy input both on
// - repeat select 0 runs one sequence, 1 restarts it endlessly
// - received bytes stored only when receive accept is 1
// - receive accept 0 leaves the serial input pin a plain port
// - busy input enable 0 leaves the busy pin a plain port
// - active flag and error flag, bits 3 and 4, ignore writes
// - completion irq flag clears on acknowledge; software polls the active flag
// - busy handshake never used while the external clock source is selected
// - gap register resets to zero and takes bit and byte writes
// - gap bit 7 selects whether the five-bit code sets the interval
// - byte spacing follows the code n in serial clock periods
// - code zero or one, or control off, gives two periods; each step above one adds one
// - busy handshake ignored while the gap register controls spacing
`timescale 1ns/1ps
module auto_serial_transfer_control
  import auto_xfer_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        link_clk,
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic [7:0]  cpu_wmask,
  output logic      [7:0]  cpu_rdata,
  input  wire logic        byte_end,
  input  wire logic        last_byte,
  input  wire logic        fault_seen,
  input  wire logic        irq_ack,
  input  wire logic        busy_pin,
  output logic             serial_done_irq_flag,
  output logic             transfer_active_flag,
  output logic             rx_store_en,
  output logic             serial_in_is_port,
  output logic             busy_pin_is_port,
  output logic             busy_gate_active,
  output logic             next_byte_go
);
  logic [7:0] gap_reg, ctrl_reg, mode_reg;
  logic       err_reg, act_reg;
  logic       shift_wr;
  logic       busy_s1_reg, busy_s2_reg;
  logic       ext_clk;
  logic       gap_ctl;
  logic       busy_use;
  logic [5:0] gap_periods;

  // clock crossing signals and gap wait state, on link and system side
  logic       load_tgl_reg;
  logic       load_l1_reg, load_l2_reg, load_l3_reg;
  logic       link_rst_reg, link_rst2_reg;
  logic       done_tgl_reg;
  logic       done_s1_reg, done_s2_reg, done_s3_reg;
  logic       gap_done;
  logic       link_load;
  logic       gap_wait_reg;
  logic       byte_pending_reg;

  assign shift_wr = cpu_wr && cpu_addr == SHIFT_ADDR;
  assign ext_clk  = mode_reg[1:0] == 2'b00;
  assign gap_ctl  = gap_reg[GAP_SEL_BIT];
  // busy handshake only when enabled, clock internal, and gap not in control
  assign busy_use = ctrl_reg[CTRL_BEN_BIT] && !ext_clk && !gap_ctl;

  // two periods without control or with code zero, else n+1 periods for n = 1..31
  always_comb begin
    if (gap_ctl && gap_reg[4:0] != 5'h00) begin
      gap_periods = {1'b0, gap_reg[4:0]} + 6'h01;
    end else begin
      gap_periods = GAP_DEFAULT;
    end
  end

  // gap register: bit and byte writes, bits 5 and 6 held at zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_reg <= GAP_RESET;
    end else if (cpu_wr && cpu_addr == GAP_ADDR) begin
      gap_reg <= (gap_reg & ~(cpu_wmask & GAP_WMASK)) | (cpu_wdata & cpu_wmask & GAP_WMASK);
    end
  end

  // control register: only writable bits are stored, bits 3 and 4 come from status
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (cpu_wr && cpu_addr == CTRL_ADDR) begin
      ctrl_reg <= (ctrl_reg & ~(cpu_wmask & CTRL_WMASK)) | (cpu_wdata & cpu_wmask & CTRL_WMASK);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_reg <= MODE_RESET;
    end else if (cpu_wr && cpu_addr == MODE_ADDR) begin
      mode_reg <= (mode_reg & ~cpu_wmask) | (cpu_wdata & cpu_wmask);
    end
  end

  // error flag: a fault in the same cycle as the shift write wins
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_reg <= 1'b0;
    end else if (fault_seen && act_reg && ctrl_reg[CTRL_CHK_BIT] && ctrl_reg[CTRL_BEN_BIT]) begin
      err_reg <= 1'b1;
    end else if (shift_wr) begin
      err_reg <= 1'b0;
    end
  end

  // active flag: set by the start write, cleared at the end of a single run
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_reg <= 1'b0;
    end else if (shift_wr && mode_reg[MODE_EN_BIT]) begin
      act_reg <= 1'b1;
    end else if (!mode_reg[MODE_EN_BIT]) begin
      act_reg <= 1'b0;
    end else if (byte_end && last_byte && !ctrl_reg[CTRL_RPT_BIT]) begin
      act_reg <= 1'b0;
    end
  end

  // completion irq flag: set wins over acknowledge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      serial_done_irq_flag <= 1'b0;
    end else if (act_reg && byte_end && last_byte) begin
      serial_done_irq_flag <= 1'b1;
    end else if (irq_ack) begin
      serial_done_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      transfer_active_flag <= 1'b0;
      rx_store_en          <= 1'b0;
      serial_in_is_port    <= 1'b1;
      busy_pin_is_port     <= 1'b1;
    end else begin
      transfer_active_flag <= act_reg;
      rx_store_en          <= act_reg && ctrl_reg[CTRL_RX_BIT];
      serial_in_is_port    <= !(mode_reg[MODE_EN_BIT] && ctrl_reg[CTRL_RX_BIT]);
      busy_pin_is_port     <= !(mode_reg[MODE_EN_BIT] && ctrl_reg[CTRL_BEN_BIT]);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_s1_reg <= 1'b0;
      busy_s2_reg <= 1'b0;
    end else begin
      busy_s1_reg <= busy_pin;
      busy_s2_reg <= busy_s1_reg;
    end
  end

  // peer busy as seen by the engine, after polarity
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_gate_active <= 1'b0;
    end else begin
      busy_gate_active <= busy_use && act_reg && (busy_s2_reg ^ ctrl_reg[CTRL_BPOL_BIT]);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
      unique case (cpu_addr)
        GAP_ADDR:  cpu_rdata <= gap_reg;
        CTRL_ADDR: cpu_rdata <= {ctrl_reg[7:5], err_reg, act_reg, 1'b0, ctrl_reg[1:0]};
        MODE_ADDR: cpu_rdata <= mode_reg;
        default:   cpu_rdata <= 8'h00;
      endcase
    end
  end

  // byte end starts a gap on the link side by toggle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      load_tgl_reg <= 1'b0;
    end else if (act_reg && byte_end && !(last_byte && !ctrl_reg[CTRL_RPT_BIT])) begin
      load_tgl_reg <= ~load_tgl_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_wait_reg <= 1'b0;
    end else if (act_reg && byte_end && !(last_byte && !ctrl_reg[CTRL_RPT_BIT])) begin
      gap_wait_reg <= 1'b1;
    end else if (done_s3_reg != done_s2_reg || !act_reg) begin
      gap_wait_reg <= 1'b0;
    end
  end

  // next byte may start: gap elapsed and peer not busy
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      byte_pending_reg <= 1'b0;
      next_byte_go     <= 1'b0;
    end else begin
      byte_pending_reg <= (byte_pending_reg || (gap_wait_reg && done_s3_reg != done_s2_reg))
                          && act_reg && !next_byte_go;
      next_byte_go     <= byte_pending_reg && !busy_gate_active && !next_byte_go;
    end
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_rst_reg  <= 1'b1;
      link_rst2_reg <= 1'b1;
    end else begin
      link_rst_reg  <= 1'b0;
      link_rst2_reg <= link_rst_reg;
    end
  end

  always_ff @(posedge link_clk or posedge link_rst2_reg) begin
    if (link_rst2_reg) begin
      load_l1_reg <= 1'b0;
      load_l2_reg <= 1'b0;
      load_l3_reg <= 1'b0;
    end else begin
      load_l1_reg <= load_tgl_reg;
      load_l2_reg <= load_l1_reg;
      load_l3_reg <= load_l2_reg;
    end
  end

  assign link_load = load_l2_reg != load_l3_reg;

  // code is static during a sequence, so it crosses as a quasi-static word
  gap_timer #(.CW(6)) u_gap (
    .link_clk (link_clk),
    .link_rst (link_rst2_reg),
    .load     (link_load),
    .periods  (gap_periods),
    .gap_done (gap_done)
  );

  always_ff @(posedge link_clk or posedge link_rst2_reg) begin
    if (link_rst2_reg) begin
      done_tgl_reg <= 1'b0;
    end else if (gap_done) begin
      done_tgl_reg <= ~done_tgl_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_s3_reg <= 1'b0;
    end else begin
      done_s1_reg <= done_tgl_reg;
      done_s2_reg <= done_s1_reg;
      done_s3_reg <= done_s2_reg;
    end
  end

  chk_err_clear_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    shift_wr && !fault_seen |=> !err_reg) else $error("error flag not cleared by shift write");
  chk_err_needs_check: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !err_reg && !(ctrl_reg[CTRL_CHK_BIT] && ctrl_reg[CTRL_BEN_BIT]) |=> !err_reg)
    else $error("error set without check enabled");
  chk_single_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
    act_reg && byte_end && last_byte && !ctrl_reg[CTRL_RPT_BIT] && !shift_wr |=> ##1 !transfer_active_flag)
    else $error("single mode did not stop");
  chk_rx_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ctrl_reg[CTRL_RX_BIT] |=> !rx_store_en) else $error("store without receive accept");
  chk_rx_port: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ctrl_reg[CTRL_RX_BIT] |=> serial_in_is_port) else $error("serial input taken from port");
  chk_busy_port: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ctrl_reg[CTRL_BEN_BIT] |=> busy_pin_is_port) else $error("busy pin taken from port");
  chk_status_ro: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cpu_wr && cpu_addr == CTRL_ADDR && !shift_wr && !fault_seen |=> $stable(err_reg))
    else $error("control write changed error flag");
  chk_irq_ack: assert property (@(posedge sys_clk) disable iff (sys_rst)
    irq_ack && !(act_reg && byte_end && last_byte) |=> !serial_done_irq_flag) else $error("irq flag not cleared");
  chk_busy_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ext_clk || gap_ctl) |=> !busy_gate_active) else $error("busy used while disallowed");
  chk_gap_bits: assert property (@(posedge sys_clk) disable iff (sys_rst)
    gap_reg[6:5] == 2'b00) else $error("gap reserved bits set");

  cov_single_run: cover property (@(posedge sys_clk) disable iff (sys_rst)
    act_reg && byte_end && last_byte && !ctrl_reg[CTRL_RPT_BIT]);
  cov_repeat_run: cover property (@(posedge sys_clk) disable iff (sys_rst)
    act_reg && byte_end && last_byte && ctrl_reg[CTRL_RPT_BIT]);
  cov_error_seen: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(err_reg));
  cov_gap_next: cover property (@(posedge sys_clk) disable iff (sys_rst) next_byte_go && gap_ctl);
endmodule

// ==== tb/busy_peer.sv ====
// far-side peripheral model: drives the busy line back to the serial port
// assumes the bench says when the peripheral is busy; no pull on the line
`timescale 1ns/1ps
module busy_peer #(
  parameter bit ACT_LOW = 1'b0
) (
  input  wire logic link_clk,
  input  wire logic busy_req,
  output logic      busy_line
);
  logic held;

  // a slow chip: busy follows the request one serial clock later
  always_ff @(posedge link_clk) begin
    held <= busy_req;
  end

  assign busy_line = (held === 1'b1) ^ ACT_LOW;
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the automatic serial transfer control block
// assumes the byte engine and the processor are played by the bench
`timescale 1ns/1ps
module testbench;
  import auto_xfer_pkg::*;
  logic        sys_clk    = 1'b0;
  logic        sys_rst    = 1'b1;
  logic        link_clk   = 1'b0;
  logic [15:0] cpu_addr   = 16'h0000;
  logic        cpu_wr     = 1'b0;
  logic        cpu_rd     = 1'b0;
  logic [7:0]  cpu_wdata  = 8'h00;
  logic [7:0]  cpu_wmask  = 8'h00;
  logic        byte_end   = 1'b0;
  logic        last_byte  = 1'b0;
  logic        fault_seen = 1'b0;
  logic        irq_ack    = 1'b0;
  logic        busy_req   = 1'b0;
  logic        busy_pin;
  logic [7:0]  cpu_rdata;
  logic        irq_f, act_f, rx_en, si_port, bz_port, bz_gate, go;
  logic [7:0]  v, r;
  int          n_errors = 0;
  int          tests_run = 0;
  int          seed = 32'h450f;
  int          k;

  always #20 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end

  busy_peer #(.ACT_LOW(1'b0)) peer (.link_clk(link_clk), .busy_req(busy_req), .busy_line(busy_pin));

  auto_serial_transfer_control uut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_clk), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_wmask(cpu_wmask),
    .cpu_rdata(cpu_rdata), .byte_end(byte_end), .last_byte(last_byte), .fault_seen(fault_seen),
    .irq_ack(irq_ack), .busy_pin(busy_pin), .serial_done_irq_flag(irq_f),
    .transfer_active_flag(act_f), .rx_store_en(rx_en), .serial_in_is_port(si_port),
    .busy_pin_is_port(bz_port), .busy_gate_active(bz_gate), .next_byte_go(go));

  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic check_rng(input string nm, input int lo, input int hi, input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
    @(negedge sys_clk);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wmask = m;
    cpu_wr = 1'b1;
    @(negedge sys_clk);
    cpu_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge sys_clk);
    cpu_rd = 1'b0;
    d = cpu_rdata;
  endtask

  // s: 0 byte end, 1 fault, 2 interrupt acknowledge
  task automatic pulse(input int s);
    @(negedge sys_clk);
    if (s == 0)
      byte_end = 1'b1;
    else if (s == 1)
      fault_seen = 1'b1;
    else
      irq_ack = 1'b1;
    @(negedge sys_clk);
    byte_end = 1'b0;
    fault_seen = 1'b0;
    irq_ack = 1'b0;
  endtask

  task automatic start_seq;
    wr(SHIFT_ADDR, 8'($random(seed)), 8'hFF);
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic end_seq;
    last_byte = 1'b1;
    pulse(0);
    last_byte = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  task automatic wait_go(output int n);
    n = 0;
    while (go !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > 300) begin
        n_errors++;
        $display("MISMATCH next_byte_go expected 1 seen none");
        final_report();
      end
    end
  endtask

  function automatic int gap_periods(input logic s, input logic [4:0] c);
    return (s && c != 5'h00) ? int'(c) + 1 : 2;
  endfunction

  task automatic gap_case(input logic s, input logic [4:0] c);
    int n, p;
    p = gap_periods(s, c);
    wr(GAP_ADDR, {s, 2'b00, c}, 8'hFF);
    start_seq();
    pulse(0);
    wait_go(n);
    check_rng("gap cycles", (p * 48) / 40 + 4, ((p + 2) * 48) / 40 + 8, n);
    end_seq();
  endtask

  initial begin
    #3000000;
    n_errors++;
    $display("MISMATCH run expected end seen timeout");
    final_report();
  end

  initial begin
    repeat (3) @(negedge sys_clk);
    check("ports rst", 8'h03, {6'h00, si_port, bz_port});
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    rd(GAP_ADDR, v);
    check("gap reset", GAP_RESET, v);
    rd(CTRL_ADDR, v);
    check("ctrl reset", CTRL_RESET, v);
    rd(16'hFF00, v);
    check("unmapped", 8'h00, v);
    wr(MODE_ADDR, 8'h81, 8'hFF);
    wr(CTRL_ADDR, 8'h1C, 8'hFF);
    rd(CTRL_ADDR, v);
    check("ctrl ro bits", 8'h00, v);
    wr(CTRL_ADDR, 8'h02, 8'hFF);
    repeat (2) @(negedge sys_clk);
    check("pins re0", 8'h02, {6'h00, si_port, bz_port});
    check("store re0", 8'h00, {7'h00, rx_en});
    wr(CTRL_ADDR, 8'h80, 8'hFF);
    start_seq();
    check("pins re1", 8'h01, {6'h00, si_port, bz_port});
    check("store re1", 8'h01, {7'h00, rx_en});
    end_seq();
    pulse(2);
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed)) & GAP_WMASK;
      wr(GAP_ADDR, v, 8'hFF);
      rd(GAP_ADDR, r);
      check("gap byte", v, r);
    end
    wr(GAP_ADDR, 8'h00, 8'hFF);
    wr(GAP_ADDR, 8'hFF, 8'h01);
    rd(GAP_ADDR, v);
    check("gap bit", 8'h01, v);
    wr(GAP_ADDR, 8'h00, 8'hFF);
    wr(CTRL_ADDR, 8'h22, 8'hFF);
    start_seq();
    pulse(1);
    rd(CTRL_ADDR, v);
    check("err set", 8'h3A, v);
    start_seq();
    rd(CTRL_ADDR, v);
    check("err clear", 8'h2A, v);
    end_seq();
    check("single end", 8'h01, {6'h00, act_f, irq_f});
    pulse(2);
    check("irq ack", 8'h00, {7'h00, irq_f});
    wr(CTRL_ADDR, 8'h20, 8'hFF);
    start_seq();
    pulse(1);
    rd(CTRL_ADDR, v);
    check("no check", 8'h28, v);
    end_seq();
    wr(CTRL_ADDR, 8'h00, 8'hFF);
    gap_case(1'b0, 5'($random(seed)));
    gap_case(1'b1, 5'h00);
    gap_case(1'b1, 5'h03);
    gap_case(1'b1, 5'h1F);
    gap_case(1'b1, 5'($random(seed)));
    wr(GAP_ADDR, 8'h00, 8'hFF);
    wr(CTRL_ADDR, 8'h02, 8'hFF);
    start_seq();
    busy_req = 1'b1;
    repeat (8) @(negedge sys_clk);
    check("busy gate", 8'h01, {7'h00, bz_gate});
    pulse(0);
    k = 0;
    repeat (40) begin
      @(negedge sys_clk);
      if (go === 1'b1)
        k++;
    end
    check("held off", 8'h00, 8'(k));
    busy_req = 1'b0;
    wait_go(k);
    end_seq();
    wr(GAP_ADDR, 8'h80, 8'hFF);
    busy_req = 1'b1;
    start_seq();
    repeat (8) @(negedge sys_clk);
    check("gap over busy", 8'h00, {7'h00, bz_gate});
    end_seq();
    wr(GAP_ADDR, 8'h00, 8'hFF);
    wr(MODE_ADDR, 8'h80, 8'hFF);
    start_seq();
    repeat (8) @(negedge sys_clk);
    check("ext clock", 8'h00, {7'h00, bz_gate});
    end_seq();
    busy_req = 1'b0;
    wr(MODE_ADDR, 8'h81, 8'hFF);
    wr(CTRL_ADDR, 8'h03, 8'hFF);
    start_seq();
    repeat (8) @(negedge sys_clk);
    check("busy low pol", 8'h01, {7'h00, bz_gate});
    end_seq();
    wr(CTRL_ADDR, 8'h40, 8'hFF);
    start_seq();
    end_seq();
    check("repeat", 8'h01, {7'h00, act_f});
    wr(CTRL_ADDR, 8'h00, 8'hFF);
    end_seq();
    check("repeat off", 8'h00, {7'h00, act_f});
    final_report();
  end
endmodule
